//--- rtl/buck_fault_pkg.sv
// buck_fault_pkg: constants, modes and carriers for the buck fault supervisor.
// assumes a 100 MHz ref_clk and comparator flags already synchronous to it.
package buck_fault_pkg;

	// clock
	localparam int clk_mhz = 100;

	// times as written, in their own units
	localparam int t_blank_ns              = 100;
	localparam int minimum_off_time_ns     = 100;
	localparam int power_good_ov_delay_ns  = 20000;
	localparam int power_good_uv_delay_ns  = 20000;
	localparam int t_soft_start_us         = 1000;
	localparam int hiccup_retry_period_us  = 5000;

	// least times round up to whole cycles
	localparam logic [7:0]  blank_cycles    = 8'((t_blank_ns * clk_mhz + 999) / 1000);
	localparam logic [7:0]  min_off_cycles  = 8'((minimum_off_time_ns * clk_mhz + 999) / 1000);
	localparam int          pg_ov_cycles    = (power_good_ov_delay_ns * clk_mhz + 999) / 1000;
	localparam int          pg_uv_cycles    = (power_good_uv_delay_ns * clk_mhz + 999) / 1000;
	localparam int          soft_cycles     = t_soft_start_us * clk_mhz;
	localparam int          hiccup_cycles   = hiccup_retry_period_us * clk_mhz;

	// fault counts in switching cycles
	localparam logic [7:0]  overcurrent_cycle_limit       = 8'h20;
	localparam logic [7:0]  switch_node_short_cycle_limit = 8'h04;
	localparam logic [1:0]  sw_persist_cycles             = 2'h3;

	// counter widths and reset values
	localparam int          timer_w   = 20;
	localparam int          filt_w    = 12;
	localparam logic        pg_oe_n_rst = 1'b0;

	typedef enum logic [2:0] {
		m_off,
		m_soft,
		m_run,
		m_hiccup,
		m_boot_wait,
		m_boot_latch
	} mode_t;

	// comparator and modulator inputs
	typedef struct packed {
		logic enable;
		logic vin_uv;
		logic osc_pulse;
		logic pwm_high;
		logic peak_oc;
		logic sw_short;
		logic boot_open;
		logic boot_short;
		logic out_ov;
		logic out_uv;
		logic over_temp;
		logic light_load;
	} sense_t;

	// gate enables and power-good drive
	typedef struct packed {
		logic hs_on;
		logic ls_on;
		logic ss_reset;
		logic comp_pulldown;
		logic power_good_out;
		logic power_good_oe_n;
		logic in_hiccup;
		logic latched;
	} drive_t;

	typedef struct packed {
		logic              clean;
		logic [filt_w-1:0] cnt;
	} filt_state_t;

endpackage : buck_fault_pkg

//--- rtl/stable_filter.sv
// stable_filter: output follows the input once it has held for CYCLES clocks.
// assumes the input is synchronous to ref_clk.
`timescale 1ns/1ps
module stable_filter #(
	parameter int CYCLES = 16
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// level in and deglitched level out
	input  wire logic raw,
	output logic      clean
);
	import buck_fault_pkg::*;

	filt_state_t cur;
	filt_state_t next_cur;

	always_comb begin
		next_cur = cur;
		if (raw == cur.clean) begin
			next_cur.cnt = '0;
		end else if (cur.cnt >= filt_w'(CYCLES - 1)) begin
			next_cur.clean = raw;
			next_cur.cnt   = '0;
		end else begin
			next_cur.cnt = cur.cnt + filt_w'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign clean = cur.clean;

endmodule : stable_filter

//--- rtl/buck_fault_supervisor.sv
// buck_fault_supervisor: gates the buck switches, runs hiccup and soft-start
// restart, and drives the open-drain power-good pin.
// assumes comparator flags and the oscillator pulse are synchronous to ref_clk.
`timescale 1ns/1ps

module buck_fault_supervisor #(
	parameter int SS_CYCLES  = buck_fault_pkg::soft_cycles,
	parameter int HIC_CYCLES = buck_fault_pkg::hiccup_cycles
) (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// comparator flags and modulator request
	input  wire buck_fault_pkg::sense_t sense,
	// gate enables and power-good drive
	output buck_fault_pkg::drive_t      drive
);
	import buck_fault_pkg::*;

	typedef struct packed {
		mode_t              mode;
		logic [timer_w-1:0] timer;
		logic [7:0]         oc_cnt;
		logic [7:0]         sw_cnt;
		logic [1:0]         sw_run;
		logic               oc_seen;
		logic               sw_seen;
		logic               per_pulse_current_protection;
		logic [7:0]         blank;
		logic [7:0]         off_tmr;
		drive_t             drv;
	} sup_state_t;

	sup_state_t cur;
	sup_state_t next_cur;

	logic ov_deg;
	logic uv_deg;

	logic uv_lock;
	logic hot;
	logic switching;
	logic hs_kill;
	logic pcp_trip;
	logic pg_low;
	logic pg_hiz;
	logic cycle_start;

	// overvoltage delay on power-good
	stable_filter #(
		.CYCLES (pg_ov_cycles)
	) u_ov_filter (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.raw     (sense.out_ov),
		.clean   (ov_deg)
	);

	// undervoltage deglitch on power-good
	stable_filter #(
		.CYCLES (pg_uv_cycles)
	) u_uv_filter (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.raw     (sense.out_uv),
		.clean   (uv_deg)
	);

	always_comb begin
		next_cur = cur;

		cycle_start = sense.osc_pulse;
		uv_lock     = !sense.enable || sense.vin_uv;
		hot         = sense.over_temp && !sense.light_load;

		// mode sequencing, highest priority first
		case (cur.mode)
			m_boot_latch: begin
				next_cur.mode = m_boot_latch;
			end
			default: begin
				if (sense.boot_short) begin
					if (cur.mode == m_run) begin
						next_cur.mode = m_boot_latch;
					end else begin
						next_cur.mode = m_boot_wait;
					end
					next_cur.timer = '0;
				end else if (uv_lock || hot) begin
					next_cur.mode  = m_off;
					next_cur.timer = '0;
				end else if (sense.boot_open && cur.mode != m_hiccup) begin
					next_cur.mode  = m_hiccup;
					next_cur.timer = '0;
				end else begin
					case (cur.mode)
						m_off, m_boot_wait: begin
							next_cur.mode  = m_soft;
							next_cur.timer = '0;
						end
						m_soft: begin
							if (cur.timer >= timer_w'(SS_CYCLES - 1)) begin
								next_cur.mode  = m_run;
								next_cur.timer = '0;
							end else begin
								next_cur.timer = cur.timer + timer_w'(1);
							end
						end
						m_run: begin
							// stop at the limiting pulse so no fresh high-side pulse starts
							if (cur.oc_cnt >= overcurrent_cycle_limit ||
							    cur.sw_cnt >= switch_node_short_cycle_limit ||
							    (cycle_start && cur.oc_seen &&
							     (cur.oc_cnt + 8'h01) >= overcurrent_cycle_limit) ||
							    (cycle_start && cur.sw_seen &&
							     (cur.sw_cnt + 8'h01) >= switch_node_short_cycle_limit)) begin
								next_cur.mode  = m_hiccup;
								next_cur.timer = '0;
							end
						end
						m_hiccup: begin
							if (cur.timer >= timer_w'(HIC_CYCLES - 1)) begin
								next_cur.mode  = m_soft;
								next_cur.timer = '0;
							end else begin
								next_cur.timer = cur.timer + timer_w'(1);
							end
						end
						default: begin
							next_cur.mode  = m_off;
							next_cur.timer = '0;
						end
					endcase
				end
			end
		endcase

		switching = (next_cur.mode == m_soft) || (next_cur.mode == m_run);

		// per-cycle fault flags, set wins over the cycle-start clear
		next_cur.oc_seen = (cycle_start ? 1'b0 : cur.oc_seen);
		next_cur.sw_seen = (cycle_start ? 1'b0 : cur.sw_seen) | sense.sw_short;

		// peak comparator only heard once blanking has run out
		pcp_trip = sense.peak_oc && cur.drv.hs_on && (cur.blank == 8'h00);
		if (pcp_trip) begin
			next_cur.oc_seen = 1'b1;
		end
		next_cur.per_pulse_current_protection = (cycle_start ? 1'b0 : cur.per_pulse_current_protection) | pcp_trip;

		// overcurrent and switch-node counters
		if (cur.mode != m_run) begin
			next_cur.oc_cnt = '0;
			next_cur.sw_cnt = '0;
			next_cur.sw_run = '0;
		end else if (cycle_start) begin
			if (cur.oc_seen) begin
				if (cur.oc_cnt != 8'hff) begin
					next_cur.oc_cnt = cur.oc_cnt + 8'h01;
				end
			end else begin
				next_cur.oc_cnt = '0;
			end
			if (cur.sw_seen) begin
				if (cur.sw_run != sw_persist_cycles) begin
					next_cur.sw_run = cur.sw_run + 2'h1;
				end
				if (cur.sw_cnt != 8'hff) begin
					next_cur.sw_cnt = cur.sw_cnt + 8'h01;
				end
			end else begin
				next_cur.sw_run = '0;
				next_cur.sw_cnt = '0;
			end
		end
		hs_kill = (cur.sw_run == sw_persist_cycles);

		// minimum off-time pulses while the output is high
		if (cur.off_tmr != 8'h00) begin
			next_cur.off_tmr = cur.off_tmr - 8'h01;
		end
		if (cycle_start && sense.out_ov && switching) begin
			next_cur.off_tmr = min_off_cycles;
		end

		// gate enables, every switch-off request ORed in
		next_cur.drv.hs_on = switching && sense.pwm_high && !next_cur.per_pulse_current_protection &&
		                     !sense.out_ov && !hs_kill;
		if (!switching) begin
			next_cur.drv.ls_on = 1'b0;
		end else if (sense.out_ov) begin
			next_cur.drv.ls_on = (next_cur.off_tmr != 8'h00);
		end else begin
			next_cur.drv.ls_on = !next_cur.drv.hs_on;
		end

		// leading-edge blanking after each high-side turn-on
		if (next_cur.drv.hs_on && !cur.drv.hs_on) begin
			next_cur.blank = blank_cycles;
		end else if (cur.blank != 8'h00) begin
			next_cur.blank = cur.blank - 8'h01;
		end

		// soft-start and compensation pull-down
		next_cur.drv.ss_reset      = !switching;
		next_cur.drv.comp_pulldown = hot;

		// power-good open-drain drive
		pg_low = (next_cur.mode != m_run) || uv_deg || ov_deg || hot;
		pg_hiz = sense.boot_short || (next_cur.mode == m_boot_wait) ||
		         (next_cur.mode == m_boot_latch);
		next_cur.drv.power_good_out  = 1'b0;
		next_cur.drv.power_good_oe_n = !(pg_low && !pg_hiz);

		// status
		next_cur.drv.in_hiccup = (next_cur.mode == m_hiccup);
		next_cur.drv.latched   = (next_cur.mode == m_boot_latch);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur                      <= '0;
			cur.mode                 <= m_off;
			cur.drv.ss_reset         <= 1'b1;
			cur.drv.power_good_oe_n  <= pg_oe_n_rst;
		end else begin
			cur <= next_cur;
		end
	end

	assign drive = cur.drv;

endmodule : buck_fault_supervisor

//--- tb/buck_fault_properties.sv
// buck_fault_properties: port timing checks for the fault supervisor.
// assumes a bind onto buck_fault_supervisor with the same counts.
`timescale 1ns/1ps
module buck_fault_properties
	import buck_fault_pkg::*;
#(
	parameter int SS_CYCLES  = 50,
	parameter int HIC_CYCLES = 100
) (
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   rst_n,
	// watched ports
	input wire buck_fault_pkg::sense_t sense,
	input wire buck_fault_pkg::drive_t drive
);
	logic [7:0]  age;
	logic [19:0] hic;
	logic [2:0]  swn;
	wire logic   cool = sense.enable && !sense.vin_uv && !sense.boot_short && !drive.latched;
	wire logic   q = cool && !sense.boot_open && !sense.over_temp && !sense.sw_short
		&& !sense.out_uv;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 8'h00;
			hic <= 20'h00000;
			swn <= 3'h0;
		end else begin
			age <= drive.hs_on ? age + 8'(age != 8'hff) : 8'h00;
			hic <= drive.in_hiccup ? hic + 20'h00001 : 20'h00000;
			swn <= !sense.sw_short ? 3'h0 : swn + 3'(sense.osc_pulse && swn != 3'h7);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence trip_late;
		drive.hs_on && age > 8'h0c && sense.peak_oc && q && !sense.out_ov;
	endsequence
	sequence trip_blank;
		drive.hs_on && age < 8'h06 && sense.peak_oc && sense.pwm_high && q && !sense.out_ov;
	endsequence
	a_input_undervoltage_lockout_off: assert property (sense.vin_uv && !sense.boot_short && !drive.latched
		|=> !drive.hs_on && !drive.ls_on && !drive.power_good_oe_n && drive.ss_reset)
		else $error("switching under input undervoltage");
	a_peak_cut: assert property (trip_late |=> !drive.hs_on && drive.ls_on)
		else $error("peak trip did not swap switches");
	a_blank_hold: assert property (trip_blank |=> drive.hs_on)
		else $error("peak trip acted inside blanking");
	a_hiccup_off: assert property (drive.in_hiccup
		|-> !drive.hs_on && !drive.ls_on && !drive.power_good_oe_n)
		else $error("switching or power-good released in hiccup");
	a_hiccup_len: assert property (drive.in_hiccup |-> hic <= 20'(HIC_CYCLES))
		else $error("hiccup wait overran");
	a_boot_hiz: assert property (sense.boot_short
		|=> drive.power_good_oe_n && !drive.hs_on && !drive.ls_on)
		else $error("boot short not high-impedance and off");
	a_latch_hold: assert property (drive.latched |=> drive.latched && !drive.hs_on)
		else $error("boot latch left without reset");
	a_ov_no_high: assert property (sense.out_ov |=> !drive.hs_on)
		else $error("high side on during overvoltage");
	a_ov_pg_wait: assert property ($rose(sense.out_ov) && drive.power_good_oe_n && q
		|=> drive.power_good_oe_n)
		else $error("power-good dropped without delay");
	a_sw_kill: assert property (swn > 3'h3 |-> !drive.hs_on)
		else $error("high side kept on into node short");
	a_heat_stop: assert property (sense.over_temp && !sense.light_load && cool
		|=> drive.comp_pulldown && !drive.hs_on && !drive.ls_on)
		else $error("hot but still switching");
	a_light_ign: assert property (sense.over_temp && sense.light_load && cool
		&& !drive.comp_pulldown |=> !drive.comp_pulldown)
		else $error("thermal acted in light load");
endmodule : buck_fault_properties

//--- tb/power_stage_model.sv
// power_stage_model: oscillator, current comparators and power-good pull-up.
// assumes hs_on is the supervisor's registered gate enable.
`timescale 1ns/1ps
module power_stage_model #(
	parameter int PER = 20
) (
	// clock, reset and commands
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic hs_on,
	input  wire logic overload,
	input  wire logic short_gnd,
	input  wire logic oe_n,
	input  wire logic pg_out,
	// comparator flags and pin level
	output logic      osc_pulse,
	output logic      peak_oc,
	output logic      sw_short,
	output logic      pg_pin
);
	int cnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			osc_pulse <= 1'b0;
		end else begin
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
			osc_pulse <= (cnt == PER - 1);
		end
	end
	// current only flows with the high side on
	assign peak_oc = overload && hs_on;
	assign sw_short = short_gnd;
	assign pg_pin = oe_n ? 1'b1 : pg_out;
endmodule : power_stage_model

//--- tb/tb_top.sv
// tb_top: self-checking bench for the buck fault supervisor.
// assumes power_stage_model gives oscillator, current flags and pull-up.
`timescale 1ns/1ps
module tb_top;
	import buck_fault_pkg::*;
	localparam int SS  = 50;
	localparam int HIC = 100;
	logic            ref_clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            ovl = 1'b0;
	logic            shrt = 1'b0;
	logic            osc, poc, sws, pg;
	sense_t          s = '0;
	sense_t          sense;
	drive_t          drive;
	wire logic [3:0] st = {drive.hs_on, drive.ls_on, pg, drive.in_hiccup};
	int              failures = 0;
	int              total_checks = 0;
	always #5 ref_clk = ~ref_clk;
	always_comb begin
		sense = s;
		sense.osc_pulse = osc;
		sense.peak_oc = poc;
		sense.sw_short = sws;
	end
	buck_fault_supervisor #(.SS_CYCLES(SS), .HIC_CYCLES(HIC)) i_buck_fault_supervisor (
		.ref_clk(ref_clk), .rst_n(rst_n), .sense(sense), .drive(drive));
	power_stage_model i_power_stage_model (.ref_clk(ref_clk), .rst_n(rst_n),
		.hs_on(drive.hs_on), .overload(ovl), .short_gnd(shrt), .oe_n(drive.power_good_oe_n),
		.pg_out(drive.power_good_out), .osc_pulse(osc), .peak_oc(poc), .sw_short(sws),
		.pg_pin(pg));
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task automatic at_osc();
		for (int i = 0; i < 40 && osc !== 1'b1; i++)
			cyc(1);
	endtask : at_osc
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic t_input_undervoltage_lockout();
		s.enable = 1'b1;
		s.vin_uv = 1'b1;
		cyc(5);
		chk({st[3:1], drive.ss_reset}, 4'h1, "uv");
		s.vin_uv = 1'b0;
		cyc(3);
		chk(st, 4'h8, "soft");
		cyc(2100);
		chk(st, 4'ha, "up");
	endtask : t_input_undervoltage_lockout
	task automatic t_peak();
		ovl = 1'b1;
		at_osc();
		cyc(6);
		chk(st, 4'ha, "blank");
		cyc(10);
		chk(st, 4'h6, "trip");
		cyc(2);
		chk(st, 4'h6, "hold");
		cyc(690);
		chk(st, 4'h1, "oc");
		cyc(HIC);
		chk({2'h0, drive.in_hiccup, drive.ss_reset}, 4'h0, "retry");
		cyc(60);
		ovl = 1'b0;
		chk({3'h0, drive.in_hiccup}, 4'h0, "ssoc");
		cyc(100);
		chk(st, 4'ha, "ocok");
	endtask : t_peak
	task automatic t_short();
		shrt = 1'b1;
		cyc(65);
		chk({3'h0, drive.hs_on}, 4'h0, "sw");
		cyc(20);
		chk(st, 4'h1, "swh");
		shrt = 1'b0;
		cyc(HIC + SS + 20);
		chk(st, 4'ha, "swok");
		s.boot_open = 1'b1;
		cyc(3);
		chk(st, 4'h1, "bo");
		s.boot_open = 1'b0;
		cyc(HIC + SS + 10);
		chk(st, 4'ha, "bok");
	endtask : t_short
	task automatic t_ov();
		s.out_ov = 1'b1;
		cyc(2);
		chk({3'h0, drive.hs_on}, 4'h0, "ov");
		at_osc();
		cyc(2);
		chk(st, 4'h6, "ovls");
		cyc(15);
		chk(st, 4'h2, "ovq");
		cyc(2000);
		chk({3'h0, pg}, 4'h0, "ovpg");
		s.out_ov = 1'b0;
		cyc(2100);
		chk(st, 4'ha, "ovok");
	endtask : t_ov
	task automatic t_heat();
		s.light_load = 1'b1;
		s.over_temp = 1'b1;
		cyc(5);
		chk({drive.comp_pulldown, st[3:1]}, 4'h5, "lp");
		s.light_load = 1'b0;
		cyc(3);
		chk({drive.comp_pulldown, st[3:1]}, 4'h8, "hot");
		s.over_temp = 1'b0;
		cyc(SS + 10);
		chk({drive.comp_pulldown, st[3:1]}, 4'h5, "cool");
	endtask : t_heat
	task automatic t_boot();
		s.boot_short = 1'b1;
		s.over_temp = 1'b1;
		cyc(3);
		chk(st, 4'h2, "bs");
		s.boot_short = 1'b0;
		s.over_temp = 1'b0;
		cyc(SS + 10);
		chk({drive.latched, drive.hs_on, drive.ls_on, 1'b0}, 4'h8, "lat");
		rst_n = 1'b0;
		s.boot_short = 1'b1;
		cyc(2);
		rst_n = 1'b1;
		cyc(SS + 10);
		chk({drive.latched, drive.hs_on, drive.ls_on, pg}, 4'h1, "bw");
		s.boot_short = 1'b0;
		cyc(SS + 10);
		chk({drive.latched, drive.hs_on, drive.ls_on, 1'b0}, 4'h4, "go");
	endtask : t_boot
	initial begin
		s.pwm_high = 1'b1;
		cyc(6);
		chk({st[3:1], drive.ss_reset}, 4'h1, "rst");
		rst_n = 1'b1;
		t_input_undervoltage_lockout();
		t_peak();
		t_short();
		t_ov();
		t_heat();
		t_boot();
		print_verdict();
	end
	initial begin
		#400000;
		failures++;
		print_verdict();
	end
endmodule : tb_top
bind buck_fault_supervisor buck_fault_properties #(.SS_CYCLES(SS_CYCLES),
	.HIC_CYCLES(HIC_CYCLES)) i_buck_fault_properties (.ref_clk(ref_clk), .rst_n(rst_n),
	.sense(sense), .drive(drive));
